/* File: logic/io_adapter_regs_shift_port.sv */
/*
 * Register bank of a peripheral interface adapter: sixteen byte registers, two ports,
 * two timers, an 8-bit synchronous shift port and four edge-sensitive control inputs.
 * Assumes the processor presents one access per strobe cycle and all pins share mclk_in.
 */
`timescale 1ns/1ns
module io_adapter_regs_shift_port #(
	parameter int SHIFT_DIV = 2
) (
	input  wire logic                          mclk_in,
	input  wire logic                          srst_in,
	input  wire io_adapter_pkg::bus_req_type   bus_req_in,
	output logic [7:0]                         rdata_out,
	output logic                               rdata_valid_out,
	input  wire logic [7:0]                    port_a_in,
	output logic [7:0]                         port_a_out,
	output logic [7:0]                         port_a_oe_out,
	input  wire logic [7:0]                    port_b_in,
	output logic [7:0]                         port_b_out,
	output logic [7:0]                         port_b_oe_out,
	input  wire logic                          port_a_control_in1_in,
	input  wire logic                          port_a_control_in2_in,
	input  wire logic                          port_b_control_in1_in,
	input  wire logic                          port_b_control_in2_in,
	input  wire logic                          shift_data_in,
	output io_adapter_pkg::shift_pins_type     shift_pins_out,
	output logic                               irq_n_out
);
	import io_adapter_pkg::*;

	// =====================================================================
	// Elaboration checks.
	if (SHIFT_DIV < 1) begin : g_bad_div
		$error("SHIFT_DIV must be at least one");
	end

	// =====================================================================
	// Access decode.
	logic [3:0]       sel;
	logic             wr_hit;
	logic             rd_hit;
	logic [7:0]       port_b_data_reg;
	logic [7:0]       port_a_data_reg;
	logic [7:0]       port_b_direction_reg;
	logic [7:0]       port_a_direction_reg;
	logic [7:0]       timer_one_low_latch_reg;
	logic [7:0]       timer_one_high_latch_reg;
	logic [15:0]      timer_one_count_reg;
	logic             timer_one_armed_reg;
	logic [7:0]       timer_two_low_latch_reg;
	logic [15:0]      timer_two_count_reg;
	logic             timer_two_armed_reg;
	logic [7:0]       serial_shift_byte_reg;
	logic [7:0]       auxiliary_control_reg;
	logic [7:0]       peripheral_line_control_reg;
	logic [6:0]       interrupt_flags_reg;
	logic [6:0]       interrupt_enables_reg;
	logic [3:0]       ctrl_prev_reg;
	logic [3:0]       ctrl_now;
	logic [3:0]       ctrl_edge;
	logic             pulse_prev_reg;
	logic             shift_active_reg;
	logic [2:0]       shift_bit_reg;
	logic             shift_clk_reg;
	logic [7:0]       shift_div_reg;
	logic             shift_tick;
	logic             shift_step;
	logic             shift_done;
	shift_source_type shift_source;

	// Select bits are gathered into one value for every access.
	assign sel    = {bus_req_in.reg_select_bit3, bus_req_in.reg_select_bit2,
			 bus_req_in.reg_select_bit1, bus_req_in.reg_select_bit0};
	assign wr_hit = bus_req_in.strobe & bus_req_in.write_en;
	assign rd_hit = bus_req_in.strobe & ~bus_req_in.write_en;

	// True when an access of the given kind hits the given register.
	function automatic logic hit(input logic kind, input logic [3:0] s, input logic [3:0] target);
		hit = kind & (s == target);
	endfunction : hit

	// =====================================================================
	// Port latches and direction registers.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			port_b_data_reg      <= BYTE_RESET;
			port_a_data_reg      <= BYTE_RESET;
			port_b_direction_reg <= BYTE_RESET;
			port_a_direction_reg <= BYTE_RESET;
		end else begin
			if (hit(wr_hit, sel, SEL_PORT_B_DATA)) begin
				port_b_data_reg <= bus_req_in.wdata;
			end
			if (hit(wr_hit, sel, SEL_PORT_A_DATA) || hit(wr_hit, sel, SEL_PORT_A_NO_HANDSHAKE)) begin
				port_a_data_reg <= bus_req_in.wdata;
			end
			if (hit(wr_hit, sel, SEL_PORT_B_DIRECTION)) begin
				port_b_direction_reg <= bus_req_in.wdata;
			end
			if (hit(wr_hit, sel, SEL_PORT_A_DIRECTION)) begin
				port_a_direction_reg <= bus_req_in.wdata;
			end
		end
	end

	// Port pins follow the latches; a direction bit of one drives the pin.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			port_a_out    <= BYTE_RESET;
			port_a_oe_out <= BYTE_RESET;
			port_b_out    <= BYTE_RESET;
			port_b_oe_out <= BYTE_RESET;
		end else begin
			port_a_out    <= port_a_data_reg;
			port_a_oe_out <= port_a_direction_reg;
			port_b_out    <= port_b_data_reg;
			port_b_oe_out <= port_b_direction_reg;
		end
	end

	// =====================================================================
	// Control registers.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			auxiliary_control_reg       <= BYTE_RESET;
			peripheral_line_control_reg <= BYTE_RESET;
			interrupt_enables_reg       <= IER_RESET;
		end else begin
			if (hit(wr_hit, sel, SEL_AUXILIARY_CONTROL)) begin
				auxiliary_control_reg <= bus_req_in.wdata;
			end
			if (hit(wr_hit, sel, SEL_PERIPHERAL_LINE_CTRL)) begin
				peripheral_line_control_reg <= bus_req_in.wdata;
			end
			// Bit 7 of the written byte says whether ones set or clear enables.
			if (hit(wr_hit, sel, SEL_INTERRUPT_ENABLES)) begin
				if (bus_req_in.wdata[FLAG_ANY]) begin
					interrupt_enables_reg <= interrupt_enables_reg | bus_req_in.wdata[6:0];
				end else begin
					interrupt_enables_reg <= interrupt_enables_reg & ~bus_req_in.wdata[6:0];
				end
			end
		end
	end

	// =====================================================================
	// Timer one: loaded from its latches on a high count write, counts down each clock.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			timer_one_low_latch_reg  <= BYTE_RESET;
			timer_one_high_latch_reg <= BYTE_RESET;
			timer_one_count_reg      <= WORD_RESET;
			timer_one_armed_reg      <= 1'b0;
		end else begin
			if (hit(wr_hit, sel, SEL_TIMER_ONE_LOW_COUNT) || hit(wr_hit, sel, SEL_TIMER_ONE_LOW_LATCH)) begin
				timer_one_low_latch_reg <= bus_req_in.wdata;
			end
			if (hit(wr_hit, sel, SEL_TIMER_ONE_HIGH_LATCH)) begin
				timer_one_high_latch_reg <= bus_req_in.wdata;
			end
			if (hit(wr_hit, sel, SEL_TIMER_ONE_HIGH_COUNT)) begin
				timer_one_high_latch_reg <= bus_req_in.wdata;
				timer_one_count_reg      <= {bus_req_in.wdata, timer_one_low_latch_reg};
				timer_one_armed_reg      <= 1'b1;
			end else if (timer_one_count_reg == WORD_RESET) begin
				// Free-running mode reloads from the latches; one-shot disarms.
				if (auxiliary_control_reg[ACR_T1_FREE_RUN]) begin
					timer_one_count_reg <= {timer_one_high_latch_reg, timer_one_low_latch_reg};
				end else begin
					timer_one_count_reg <= timer_one_count_reg - 16'h0001;
					timer_one_armed_reg <= 1'b0;
				end
			end else begin
				timer_one_count_reg <= timer_one_count_reg - 16'h0001;
			end
		end
	end

	// =====================================================================
	// Timer two: interval mode counts clocks, pulse mode counts falling edges on port B line 6.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			timer_two_low_latch_reg <= BYTE_RESET;
			timer_two_count_reg     <= WORD_RESET;
			timer_two_armed_reg     <= 1'b0;
			pulse_prev_reg          <= 1'b0;
		end else begin
			pulse_prev_reg <= port_b_in[PORT_B_PULSE_BIT];
			if (hit(wr_hit, sel, SEL_TIMER_TWO_LOW_COUNT)) begin
				timer_two_low_latch_reg <= bus_req_in.wdata;
			end
			if (hit(wr_hit, sel, SEL_TIMER_TWO_HIGH_COUNT)) begin
				timer_two_count_reg <= {bus_req_in.wdata, timer_two_low_latch_reg};
				timer_two_armed_reg <= 1'b1;
			end else if (!auxiliary_control_reg[ACR_T2_PULSES] ||
				     (pulse_prev_reg && !port_b_in[PORT_B_PULSE_BIT])) begin
				// The count rolls over and keeps running; only the first timeout flags.
				timer_two_count_reg <= timer_two_count_reg - 16'h0001;
				if (timer_two_count_reg == WORD_RESET) begin
					timer_two_armed_reg <= 1'b0;
				end
			end
		end
	end

	// =====================================================================
	// Control input edge detection with per-line polarity from the line control register.
	assign ctrl_now = {port_b_control_in2_in, port_b_control_in1_in,
			   port_a_control_in2_in, port_a_control_in1_in};

	// Previous levels track the pins through reset, so no false edge follows its release.
	always_ff @(posedge mclk_in) begin
		ctrl_prev_reg <= ctrl_now;
	end

	// Polarity bit zero picks the falling edge, one the rising edge.
	for (genvar i = 0; i < 4; i++) begin : g_ctrl_edge
		localparam int POL_BIT = (i == 0) ? 0 : (i == 1) ? 2 : (i == 2) ? 4 : 6;
		assign ctrl_edge[i] = peripheral_line_control_reg[POL_BIT] ?
				      (~ctrl_prev_reg[i] & ctrl_now[i]) :
				      (ctrl_prev_reg[i] & ~ctrl_now[i]);
	end

	// =====================================================================
	// Shift port clock source and pacing.
	assign shift_source = shift_source_type'(auxiliary_control_reg[ACR_SHIFT_LSB +: 2]);
	assign shift_tick   = (shift_div_reg == BYTE_RESET);
	assign shift_step   = shift_active_reg &&
			      ((shift_source == SHIFT_EXTERNAL) ? ctrl_edge[2] :
			       (shift_tick && !shift_clk_reg));
	assign shift_done   = shift_step && (shift_bit_reg == LAST_BIT_INDEX);

	// Divider reloads from the timer two low latch or from the fixed system rate.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			shift_div_reg <= BYTE_RESET;
		end else if (!shift_active_reg || shift_tick) begin
			shift_div_reg <= (shift_source == SHIFT_TIMER_TWO) ? timer_two_low_latch_reg :
					 8'(SHIFT_DIV - 1);
		end else begin
			shift_div_reg <= shift_div_reg - 8'h01;
		end
	end

	// Serial clock idles high; with an internal source it drops for half a bit and rises on each step.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			shift_clk_reg <= 1'b1;
		end else if (!shift_active_reg || shift_source == SHIFT_EXTERNAL) begin
			shift_clk_reg <= 1'b1;
		end else if (shift_tick) begin
			shift_clk_reg <= ~shift_clk_reg;
		end
	end

	// =====================================================================
	// Shift register, bit counter and start triggers.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			serial_shift_byte_reg <= BYTE_RESET;
			shift_bit_reg         <= 3'h0;
			shift_active_reg      <= 1'b0;
		end else begin
			if (hit(wr_hit, sel, SEL_SERIAL_SHIFT_BYTE)) begin
				serial_shift_byte_reg <= bus_req_in.wdata;
				shift_bit_reg         <= 3'h0;
				shift_active_reg      <= (shift_source != SHIFT_OFF);
			end else if (hit(rd_hit, sel, SEL_SERIAL_SHIFT_BYTE)) begin
				shift_bit_reg    <= 3'h0;
				shift_active_reg <= (shift_source != SHIFT_OFF) &&
						    !auxiliary_control_reg[ACR_SHIFT_OUT];
			end else if (shift_step) begin
				// Outgoing bits rotate back in; incoming bits enter at the bottom.
				serial_shift_byte_reg <= {serial_shift_byte_reg[6:0],
							  auxiliary_control_reg[ACR_SHIFT_OUT] ?
							  serial_shift_byte_reg[7] : shift_data_in};
				shift_bit_reg         <= shift_bit_reg + 3'h1;
				if (shift_done) begin
					shift_active_reg <= 1'b0;
				end
			end
		end
	end

	// Serial pins: data carries the top bit, so the first bit out is the most significant.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			shift_pins_out <= '{shift_clk: 1'b1, shift_data: 1'b0};
		end else begin
			shift_pins_out.shift_clk  <= shift_clk_reg;
			shift_pins_out.shift_data <= serial_shift_byte_reg[7];
		end
	end

	// =====================================================================
	// Interrupt flags: hardware sets win over the clears of the same cycle.
	always_ff @(posedge mclk_in) begin
		logic [6:0] set_v;
		logic [6:0] clr_v;
		set_v = 7'h00;
		clr_v = 7'h00;
		if (srst_in) begin
			interrupt_flags_reg <= 7'h00;
		end else begin
			set_v[FLAG_A_CTRL1]   = ctrl_edge[0];
			set_v[FLAG_A_CTRL2]   = ctrl_edge[1];
			set_v[FLAG_B_CTRL1]   = ctrl_edge[2];
			set_v[FLAG_B_CTRL2]   = ctrl_edge[3];
			set_v[FLAG_SHIFT]     = shift_done;
			set_v[FLAG_TIMER_ONE] = timer_one_armed_reg && (timer_one_count_reg == WORD_RESET);
			set_v[FLAG_TIMER_TWO] = timer_two_armed_reg && (timer_two_count_reg == WORD_RESET) &&
						(!auxiliary_control_reg[ACR_T2_PULSES] ||
						 (pulse_prev_reg && !port_b_in[PORT_B_PULSE_BIT]));
			if (hit(wr_hit, sel, SEL_INTERRUPT_FLAGS)) begin
				clr_v = bus_req_in.wdata[6:0];
			end
			// Port A handshake reads and writes clear the control 1 flag, and the control 2 flag unless line control bit 1 is set; select 15 does not.
			if (hit(bus_req_in.strobe, sel, SEL_PORT_A_DATA)) begin
				clr_v[FLAG_A_CTRL1] = 1'b1;
				clr_v[FLAG_A_CTRL2] = ~peripheral_line_control_reg[1];
			end
			if (hit(bus_req_in.strobe, sel, SEL_PORT_B_DATA)) begin
				clr_v[FLAG_B_CTRL1] = 1'b1;
				clr_v[FLAG_B_CTRL2] = ~peripheral_line_control_reg[5];
			end
			if (hit(rd_hit, sel, SEL_TIMER_ONE_LOW_COUNT) || hit(wr_hit, sel, SEL_TIMER_ONE_HIGH_COUNT)) begin
				clr_v[FLAG_TIMER_ONE] = 1'b1;
			end
			if (hit(rd_hit, sel, SEL_TIMER_TWO_LOW_COUNT) || hit(wr_hit, sel, SEL_TIMER_TWO_HIGH_COUNT)) begin
				clr_v[FLAG_TIMER_TWO] = 1'b1;
			end
			if (hit(bus_req_in.strobe, sel, SEL_SERIAL_SHIFT_BYTE)) begin
				clr_v[FLAG_SHIFT] = 1'b1;
			end
			interrupt_flags_reg <= (interrupt_flags_reg & ~clr_v) | set_v;
		end
	end

	// Interrupt request is low while any enabled flag stands.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			irq_n_out <= 1'b1;
		end else begin
			irq_n_out <= ~|(interrupt_flags_reg & interrupt_enables_reg);
		end
	end

	// =====================================================================
	// Read data, answered one clock after the strobe.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			rdata_out       <= BYTE_RESET;
			rdata_valid_out <= 1'b0;
		end else begin
			rdata_valid_out <= rd_hit;
			if (rd_hit) begin
				unique case (sel)
					SEL_PORT_B_DATA:          rdata_out <= port_b_in;
					SEL_PORT_A_DATA,
					SEL_PORT_A_NO_HANDSHAKE:  rdata_out <= port_a_in;
					SEL_PORT_B_DIRECTION:     rdata_out <= port_b_direction_reg;
					SEL_PORT_A_DIRECTION:     rdata_out <= port_a_direction_reg;
					SEL_TIMER_ONE_LOW_COUNT:  rdata_out <= timer_one_count_reg[7:0];
					SEL_TIMER_ONE_HIGH_COUNT: rdata_out <= timer_one_count_reg[15:8];
					SEL_TIMER_ONE_LOW_LATCH:  rdata_out <= timer_one_low_latch_reg;
					SEL_TIMER_ONE_HIGH_LATCH: rdata_out <= timer_one_high_latch_reg;
					SEL_TIMER_TWO_LOW_COUNT:  rdata_out <= timer_two_count_reg[7:0];
					SEL_TIMER_TWO_HIGH_COUNT: rdata_out <= timer_two_count_reg[15:8];
					SEL_SERIAL_SHIFT_BYTE:    rdata_out <= serial_shift_byte_reg;
					SEL_AUXILIARY_CONTROL:    rdata_out <= auxiliary_control_reg;
					SEL_PERIPHERAL_LINE_CTRL: rdata_out <= peripheral_line_control_reg;
					SEL_INTERRUPT_FLAGS:      rdata_out <= {|(interrupt_flags_reg & interrupt_enables_reg),
										interrupt_flags_reg};
					SEL_INTERRUPT_ENABLES:    rdata_out <= {1'b1, interrupt_enables_reg};
				endcase
			end
		end
	end

endmodule : io_adapter_regs_shift_port

/* File: logic/io_adapter_pkg.sv */
/*
 * Constants, register map, field layout and carrier types for the I/O adapter register bank.
 * Assumes a single processor-side clock; all pins are synchronous to it.
 */
// Overview of operation
// - Four select bits pick one of sixteen byte registers on every access.
// - Port B direction sits at 2, port A direction at 3, both read/write.
// - Select 15 acts like select 1 but causes no port A handshake.
// - Writing the shift byte register starts shifting that byte out.
// - Reading the shift byte register starts clocking a new byte in.
// - Shift port flag rises once a byte transfer has completed.
// - Every shift transfer moves exactly eight bits.
// - Four control inputs are edge sensitive, negative edge selectable.
// - Timer two low write fills a latch; read returns live low count.
// - Reading timer two low clears its flag and releases the interrupt.
// - Shift port sends and receives the most significant bit first.
package io_adapter_pkg;

	// =====================================================================
	// Register select values.
	localparam logic [3:0] SEL_PORT_B_DATA          = 4'h0;
	localparam logic [3:0] SEL_PORT_A_DATA          = 4'h1;
	localparam logic [3:0] SEL_PORT_B_DIRECTION     = 4'h2;
	localparam logic [3:0] SEL_PORT_A_DIRECTION     = 4'h3;
	localparam logic [3:0] SEL_TIMER_ONE_LOW_COUNT  = 4'h4;
	localparam logic [3:0] SEL_TIMER_ONE_HIGH_COUNT = 4'h5;
	localparam logic [3:0] SEL_TIMER_ONE_LOW_LATCH  = 4'h6;
	localparam logic [3:0] SEL_TIMER_ONE_HIGH_LATCH = 4'h7;
	localparam logic [3:0] SEL_TIMER_TWO_LOW_COUNT  = 4'h8;
	localparam logic [3:0] SEL_TIMER_TWO_HIGH_COUNT = 4'h9;
	localparam logic [3:0] SEL_SERIAL_SHIFT_BYTE    = 4'hA;
	localparam logic [3:0] SEL_AUXILIARY_CONTROL    = 4'hB;
	localparam logic [3:0] SEL_PERIPHERAL_LINE_CTRL = 4'hC;
	localparam logic [3:0] SEL_INTERRUPT_FLAGS      = 4'hD;
	localparam logic [3:0] SEL_INTERRUPT_ENABLES    = 4'hE;
	localparam logic [3:0] SEL_PORT_A_NO_HANDSHAKE  = 4'hF;

	// =====================================================================
	// Interrupt flag bit positions.
	localparam int FLAG_A_CTRL2     = 0;
	localparam int FLAG_A_CTRL1     = 1;
	localparam int FLAG_SHIFT       = 2;
	localparam int FLAG_B_CTRL2     = 3;
	localparam int FLAG_B_CTRL1     = 4;
	localparam int FLAG_TIMER_TWO   = 5;
	localparam int FLAG_TIMER_ONE   = 6;
	localparam int FLAG_ANY         = 7;

	// =====================================================================
	// Auxiliary control fields.
	localparam int ACR_SHIFT_LSB    = 2;
	localparam int ACR_SHIFT_OUT    = 4;
	localparam int ACR_T2_PULSES    = 5;
	localparam int ACR_T1_FREE_RUN  = 6;
	localparam int PORT_B_PULSE_BIT = 6;

	// =====================================================================
	// Reset values and counts.
	localparam logic [7:0]  BYTE_RESET      = 8'h00;
	localparam logic [15:0] WORD_RESET      = 16'h0000;
	localparam logic [6:0]  IER_RESET       = 7'h00;
	localparam logic [2:0]  LAST_BIT_INDEX  = 3'h7;
	localparam int          SHIFT_DIV_RESET = 2;

	// Shift port clock source, taken from two bits of the auxiliary control.
	typedef enum logic [1:0] {
		SHIFT_OFF,
		SHIFT_TIMER_TWO,
		SHIFT_SYSTEM_RATE,
		SHIFT_EXTERNAL
	} shift_source_type;

	// One processor access, presented for a single clock.
	typedef struct packed {
		logic       strobe;
		logic       write_en;
		logic       reg_select_bit3;
		logic       reg_select_bit2;
		logic       reg_select_bit1;
		logic       reg_select_bit0;
		logic [7:0] wdata;
	} bus_req_type;

	// Serial shift port pins.
	typedef struct packed {
		logic shift_clk;
		logic shift_data;
	} shift_pins_type;

endpackage : io_adapter_pkg

/* File: test/io_adapter_assertions.sv */
/*
 * Checker for the I/O adapter register bank, watching only the ports of its top module.
 * Assumes one clock, mclk_in, with srst_in as a synchronous active-high reset.
 */
`timescale 1ns/1ns
module io_adapter_assertions (
	input  wire logic                           mclk_in,
	input  wire logic                           srst_in,
	input  wire io_adapter_pkg::bus_req_type    bus_req_in,
	input  wire logic [7:0]                     rdata_out,
	input  wire logic                           rdata_valid_out,
	input  wire logic [7:0]                     port_a_in,
	input  wire logic [7:0]                     port_b_oe_out,
	input  wire io_adapter_pkg::shift_pins_type shift_pins_out,
	input  wire logic                           irq_n_out
);
	import io_adapter_pkg::*;
	// =====================================================================
	// Helper decode and shift clock rise count.
	logic [3:0] sel;
	logic       rd;
	logic       wr;
	logic       clk_prev;
	logic [3:0] rise_cnt;
	assign sel = {bus_req_in.reg_select_bit3, bus_req_in.reg_select_bit2, bus_req_in.reg_select_bit1,
		bus_req_in.reg_select_bit0};
	assign rd = bus_req_in.strobe & ~bus_req_in.write_en;
	assign wr = bus_req_in.strobe & bus_req_in.write_en;
	// Saturates, so a runaway clock still shows.
	always_ff @(posedge mclk_in) begin
		clk_prev <= shift_pins_out.shift_clk;
		if (srst_in || (bus_req_in.strobe && sel == SEL_SERIAL_SHIFT_BYTE)) begin
			rise_cnt <= 4'h0;
		end else if (shift_pins_out.shift_clk && !clk_prev && rise_cnt != 4'hF) begin
			rise_cnt <= rise_cnt + 4'h1;
		end
	end
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	// Every read is answered one cycle later, and only reads are answered.
	a_read_answer: assert property (rd |=> rdata_valid_out) else $error("read gave no valid pulse");
	a_valid_cause: assert property (rdata_valid_out |-> $past(rd)) else $error("valid without read");
	// Port B direction register reaches its output enables and reads back.
	a_dirb_oe: assert property (
		wr && sel == SEL_PORT_B_DIRECTION |-> ##2 port_b_oe_out == $past(bus_req_in.wdata, 2))
		else $error("port B enables do not follow direction write");
	a_dirb_read: assert property (
		rd && sel == SEL_PORT_B_DIRECTION |=> rdata_out == port_b_oe_out) else $error("direction readback wrong");
	a_pins_read: assert property (
		rd && (sel == SEL_PORT_A_DATA || sel == SEL_PORT_A_NO_HANDSHAKE) |=> rdata_out == $past(port_a_in))
		else $error("port A read does not return pins");
	// The shift byte puts its top bit on the data pin first.
	a_shift_msb: assert property (
		wr && sel == SEL_SERIAL_SHIFT_BYTE |-> ##2 shift_pins_out.shift_data == $past(bus_req_in.wdata[7], 2))
		else $error("shift data does not start with top bit");
	a_eight_steps: assert property (rise_cnt <= 4'h8) else $error("more than eight shift steps");
	a_flag_irq: assert property (
		rd && sel == SEL_INTERRUPT_FLAGS |=> rdata_out[7] == !irq_n_out) else $error("flag summary and irq differ");
	c_full_byte: cover property (rise_cnt == 4'h8);
	c_irq_fall: cover property ($fell(irq_n_out));
	c_quiet_read: cover property (rd && sel == SEL_PORT_A_NO_HANDSHAKE);
endmodule : io_adapter_assertions

bind io_adapter_regs_shift_port io_adapter_assertions chk (.*);

/* File: test/shift_peripheral_model.sv */
/*
 * Serial peripheral at the shift port's far side.
 * Assumes the shift pins are synchronous to mclk_in and restart_in marks a new transfer.
 */
`timescale 1ns/1ns
module shift_peripheral_model (
	input  wire logic                           mclk_in,
	input  wire logic                           restart_in,
	input  wire logic [7:0]                     tx_byte_in,
	input  wire io_adapter_pkg::shift_pins_type shift_pins_in,
	output logic                                shift_data_out,
	output logic [7:0]                          rx_byte_out,
	output logic [3:0]                          rx_count_out
);
	import io_adapter_pkg::*;
	logic       clk_prev;
	logic [3:0] tx_idx;
	// Capture on falling clock, where data is stable; advance the sent bit after each rise.
	always_ff @(posedge mclk_in) begin
		clk_prev <= shift_pins_in.shift_clk;
		if (restart_in) begin
			tx_idx <= 4'h0;
			rx_count_out <= 4'h0;
		end else begin
			if (clk_prev && !shift_pins_in.shift_clk) begin
				rx_byte_out <= {rx_byte_out[6:0], shift_pins_in.shift_data};
				rx_count_out <= rx_count_out + 4'h1;
			end
			if (!clk_prev && shift_pins_in.shift_clk && tx_idx != 4'h8) begin
				tx_idx <= tx_idx + 4'h1;
			end
		end
	end
	// Top bit first; once the byte is done the line carries the inverse of bit 0.
	assign shift_data_out = tx_idx[3] ? ~tx_byte_in[0] : tx_byte_in[3'h7 - tx_idx[2:0]];
endmodule : shift_peripheral_model

/* File: test/tb.sv */
/*
 * Self-checking bench for the I/O adapter register bank and its serial peripheral.
 * Assumes the package is compiled first; SHIFT_DIV is kept small to shorten transfers.
 */
`timescale 1ns/1ns
module tb;
	import io_adapter_pkg::*;
	typedef struct {logic we; logic [3:0] sel; logic [7:0] wd; logic [7:0] exp;} row_type;
	logic           mclk_in = 1'b0;
	logic           srst_in = 1'b1;
	bus_req_type    bus_req_in = '0;
	logic [7:0]     port_a_in = 8'h3C;
	logic [7:0]     port_b_in = 8'h96;
	logic [3:0]     ctrl = 4'hF;
	logic           restart = 1'b1;
	logic [7:0]     rdata_out, port_a_out, port_a_oe_out, port_b_out, port_b_oe_out, rx_byte, got, prev_got;
	logic           rdata_valid_out, irq_n_out, shift_data_in;
	logic [3:0]     rx_count;
	shift_pins_type shift_pins_out;
	logic [7:0]     fbit [4] = '{8'h02, 8'h01, 8'h10, 8'h08};
	row_type        rows [13];
	int             n_errors = 0;
	int             checks = 0;
	int             cycles = 0;
	// =====================================================================
	// Clock, cycle ceiling and the units under test.
	always #2 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			n_errors++;
			test_done();
		end
	end
	io_adapter_regs_shift_port #(.SHIFT_DIV(2)) dut (.*, .port_a_control_in1_in(ctrl[0]),
		.port_a_control_in2_in(ctrl[1]), .port_b_control_in1_in(ctrl[2]), .port_b_control_in2_in(ctrl[3]));
	shift_peripheral_model peer (.mclk_in(mclk_in), .restart_in(restart), .tx_byte_in(8'h3B),
		.shift_pins_in(shift_pins_out), .shift_data_out(shift_data_in), .rx_byte_out(rx_byte),
		.rx_count_out(rx_count));
	// Byte comparison; one-bit results are passed zero-extended.
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp8
	// One register access; the read byte is taken the cycle after its valid pulse, while rdata_out holds it.
	task automatic acc(input logic we, input logic [3:0] sel, input logic [7:0] wd);
		@(posedge mclk_in) #1;
		bus_req_in = {1'b1, we, sel, wd};
		@(posedge mclk_in) #1;
		bus_req_in.strobe = 1'b0;
		@(posedge mclk_in) #1;
		got = rdata_out;
	endtask : acc
	// Bounded wait for irq low.
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq_n_out !== 1'b0 && n < 400) begin
			@(posedge mclk_in) #1;
			n++;
		end
		cmp8({7'h0, irq_n_out}, 8'h00);
	endtask : wait_irq
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done
	// Main sequence.
	initial begin
		rows = '{'{0, 4'h2, 8'h00, 8'h00}, '{1, 4'h2, 8'h5A, 8'h00}, '{0, 4'h2, 8'h00, 8'h5A},
			'{1, 4'h3, 8'hC3, 8'h00}, '{0, 4'h3, 8'h00, 8'hC3}, '{1, 4'h0, 8'h11, 8'h00}, '{0, 4'h0, 8'h00, 8'h96},
			'{0, 4'h1, 8'h00, 8'h3C}, '{0, 4'hF, 8'h00, 8'h3C}, '{1, 4'h6, 8'h77, 8'h00}, '{0, 4'h6, 8'h00, 8'h77},
			'{1, 4'hE, 8'h7F, 8'h00}, '{0, 4'hE, 8'h00, 8'h80}};
		repeat (12) @(posedge mclk_in);
		#1 srst_in = 1'b0;
		restart = 1'b0;
		cmp8({6'h0, irq_n_out, shift_pins_out.shift_clk}, 8'h03);
		for (int i = 0; i < 13; i++) begin
			acc(rows[i].we, rows[i].sel, rows[i].wd);
			if (!rows[i].we) cmp8(got, rows[i].exp);
		end
		cmp8(port_b_out, 8'h11);
		cmp8(port_a_oe_out, 8'hC3);
		$display("test register table done");
		acc(1, SEL_AUXILIARY_CONTROL, 8'h18);
		acc(1, SEL_INTERRUPT_ENABLES, 8'h84);
		acc(1, SEL_SERIAL_SHIFT_BYTE, 8'hA5);
		wait_irq();
		cmp8(rx_byte, 8'hA5);
		cmp8({4'h0, rx_count}, 8'h08);
		acc(0, SEL_INTERRUPT_FLAGS, 8'h00);
		cmp8(got & 8'h84, 8'h84);
		acc(1, SEL_AUXILIARY_CONTROL, 8'h08);
		acc(1, SEL_INTERRUPT_FLAGS, 8'h7F);
		restart = 1'b1;
		@(posedge mclk_in) #1 restart = 1'b0;
		acc(0, SEL_SERIAL_SHIFT_BYTE, 8'h00);
		wait_irq();
		acc(0, SEL_SERIAL_SHIFT_BYTE, 8'h00);
		cmp8(got, 8'h3B);
		acc(1, SEL_AUXILIARY_CONTROL, 8'h00);
		acc(1, SEL_INTERRUPT_FLAGS, 8'h7F);
		acc(1, SEL_INTERRUPT_ENABLES, 8'h7F);
		$display("test shift port done");
		for (int i = 0; i < 4; i++) begin
			acc(1, SEL_INTERRUPT_ENABLES, 8'h80 | fbit[i]);
			ctrl[i] = 1'b0;
			wait_irq();
			acc(0, SEL_INTERRUPT_FLAGS, 8'h00);
			cmp8(got & 8'h1B, fbit[i]);
			if (i == 0) begin
				acc(0, SEL_PORT_A_NO_HANDSHAKE, 8'h00);
				acc(0, SEL_INTERRUPT_FLAGS, 8'h00);
				cmp8(got & 8'h02, 8'h02);
				acc(0, SEL_PORT_A_DATA, 8'h00);
				acc(0, SEL_INTERRUPT_FLAGS, 8'h00);
				cmp8(got & 8'h02, 8'h00);
			end
			acc(1, SEL_INTERRUPT_FLAGS, fbit[i]);
			acc(1, SEL_INTERRUPT_ENABLES, 8'h7F);
			ctrl[i] = 1'b1;
		end
		$display("test control inputs done");
		acc(1, SEL_INTERRUPT_ENABLES, 8'hA0);
		acc(1, SEL_TIMER_TWO_LOW_COUNT, 8'h05);
		acc(1, SEL_TIMER_TWO_HIGH_COUNT, 8'h00);
		wait_irq();
		acc(0, SEL_TIMER_TWO_LOW_COUNT, 8'h00);
		prev_got = got;
		acc(0, SEL_INTERRUPT_FLAGS, 8'h00);
		cmp8({got[5], irq_n_out}, 8'h01);
		acc(0, SEL_TIMER_TWO_LOW_COUNT, 8'h00);
		cmp8({7'h0, got != prev_got}, 8'h01);
		$display("test timer two done");
		test_done();
	end
endmodule : tb
